// file: dv/dgcs_host_model.sv
// Host model driving the byte register port
`timescale 1ns/1ps
module dgcs_host_model (
   input  wire logic       i_ref_clk,
   input  wire logic [7:0] i_reg_rdata,
   input  wire logic       i_reg_rvalid,
   output logic      [7:0] o_reg_addr,
   output logic            o_reg_wr,
   output logic      [7:0] o_reg_wdata,
   output logic            o_reg_rd
);
   initial {o_reg_addr, o_reg_wr, o_reg_wdata, o_reg_rd} = 18'h0;
   // Offset inverted once released, so a stale one is never reused
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_ref_clk);
      o_reg_addr = a;
      o_reg_wdata = d;
      o_reg_wr = 1'b1;
      @(negedge i_ref_clk);
      o_reg_wr = 1'b0;
      o_reg_addr = ~a;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_ref_clk);
      o_reg_addr = a;
      o_reg_rd = 1'b1;
      @(negedge i_ref_clk);
      o_reg_rd = 1'b0;
      o_reg_addr = ~a;
      d = i_reg_rvalid ? i_reg_rdata : 8'hXX;
   endtask
endmodule

// file: dv/dgcs_regs_monitor.sv
// Port assertions for the register bank
`timescale 1ns/1ps
module dgcs_regs_monitor (
   input wire logic       i_ref_clk,
   input wire logic       i_rst_n,
   input wire logic [7:0] i_reg_addr,
   input wire logic       i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic       i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   input wire logic       o_reg_rvalid,
   input wire logic       i_pcm_mode,
   input wire logic       i_automute_active,
   input wire logic       i_loop_locked,
   input wire logic       i_timing_master,
   input wire logic       i_fixed_oversample_clock_mode,
   input wire logic [7:0] o_channel_boost_active,
   input wire logic       o_nco_enable
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   // Status bits are live at the read edge, so $past is exact
   sequence stat_rd;
      i_reg_rd && i_reg_addr == dgcs_pkg::DGCS_ADDR_STATUS;
   endsequence
   sequence boost_wr;
      i_reg_wr && i_reg_addr == dgcs_pkg::DGCS_ADDR_BOOST;
   endsequence
   read_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
      else $error("read not answered");
   answer_pulse_a: assert property (o_reg_rvalid |->
      $past(i_reg_rd)) else $error("answer without read");
   part_code_a: assert property (stat_rd |=>
      o_reg_rdata[7:2] == dgcs_pkg::DGCS_PART_ID) else $error("bad part code");
   mute_flag_a: assert property (stat_rd |=>
      o_reg_rdata[1] == $past(i_automute_active)) else $error("bad mute flag");
   lock_flag_a: assert property (stat_rd |=> o_reg_rdata[0] ==
      ($past(i_loop_locked) || $past(i_timing_master) ||
      $past(i_fixed_oversample_clock_mode) || $past(o_nco_enable)))
      else $error("bad lock flag");
   pin_reserved_a: assert property (i_reg_rd &&
      i_reg_addr == dgcs_pkg::DGCS_ADDR_PIN |=> o_reg_rdata[7:1] == 7'h00)
      else $error("pin reserved bits set");
   boost_gate_a: assert property (!i_pcm_mode |->
      o_channel_boost_active == 8'h00) else $error("boost outside pcm");
   boost_write_a: assert property (boost_wr ##1 i_pcm_mode |->
      o_channel_boost_active == $past(i_reg_wdata)) else $error("bad boost");
endmodule
bind dgcs_regs dgcs_regs_monitor u_dgcs_regs_monitor (.*);

// file: dv/tb_dgcs_regs.sv
// Self-checking bench for the register bank
`timescale 1ns/1ps
module tb_dgcs_regs;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  addr, wdata, rdata, boost;
   logic        wr, rd, rvalid, cen, csel, ccont, ncoen;
   logic        pcm = 1'b0, mute = 1'b0, lk = 1'b0, mst = 1'b0;
   logic        fix = 1'b0, pin = 1'b0;
   logic [31:0] rate = 32'h0, nco = 32'h0;
   logic [1:0]  shp;
   int          n_fail = 0, samples_checked = 0;
   always #2.5 clk = ~clk;
   dgcs_regs u_dgcs_regs (
      .i_ref_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr),
      .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
      .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_pcm_mode(pcm),
      .i_automute_active(mute), .i_loop_locked(lk),
      .i_timing_master(mst), .i_fixed_oversample_clock_mode(fix),
      .i_rate_ratio(rate), .i_nco_ratio(nco), .i_general_pin_one(pin),
      .o_channel_boost_active(boost), .o_calib_enable(cen),
      .o_calib_use_second_analog_input(csel),
      .o_calib_continuous(ccont), .o_modulator_shaping(shp),
      .o_nco_enable(ncoen));
   dgcs_host_model u_dgcs_host_model (
      .i_ref_clk(clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid),
      .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_wdata(wdata), .o_reg_rd(rd));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      u_dgcs_host_model.rd(a, d);
      chk({24'h0, d}, {24'h0, e});
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Whole run is under a few hundred cycles
   initial begin
      #50000;
      n_fail++;
      report_and_stop;
   end
   initial begin
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      rc(8'h3E, 8'h00);
      rc(8'h3F, 8'h06);
      pcm = 1'b1;
      for (int c = 0; c < 8; c++) begin
         u_dgcs_host_model.wr(8'h3E, 8'h01 << c);
         chk({24'h0, boost}, 32'h1 << c);
      end
      pcm = 1'b0;
      #1 chk({24'h0, boost}, 32'h0);
      u_dgcs_host_model.wr(8'h3F, 8'hE8);
      chk({27'h0, cen, csel, ccont, shp}, 32'h1E);
      u_dgcs_host_model.wr(8'h3F, 8'hC8);
      chk({27'h0, cen, csel, ccont, shp}, 32'h1A);
      u_dgcs_host_model.wr(8'h3F, 8'h68);
      chk({27'h0, cen, csel, ccont, shp}, 32'h0A);
      for (int i = 0; i < 5; i++) begin
         mute = i[0];
         lk = (i == 1);
         mst = (i == 2);
         fix = (i == 3);
         nco = (i == 4) ? 32'h1 : 32'h0;
         rc(8'h40, {dgcs_pkg::DGCS_PART_ID, i[0], i != 0});
         chk({31'h0, ncoen}, {31'h0, i == 4});
      end
      pin = 1'b1;
      repeat (3) @(negedge clk);
      rc(8'h41, 8'h01);
      pin = 1'b0;
      repeat (3) @(negedge clk);
      rc(8'h41, 8'h00);
      lk = 1'b1;
      rate = 32'h89ABCDEF;
      rc(8'h42, 8'hEF);
      rate = 32'h12345678;
      rc(8'h43, 8'hCD);
      rc(8'h44, 8'hAB);
      rc(8'h45, 8'h89);
      for (int a = 64; a < 70; a++) begin
         u_dgcs_host_model.wr(8'(a), 8'hFF);
      end
      u_dgcs_host_model.wr(8'h50, 8'h5A);
      rc(8'h3E, 8'h80);
      rc(8'h3F, 8'h68);
      rc(8'h43, 8'hCD);
      rc(8'h50, 8'h00);
      // Unlocked loop offers no ratio, so the capture is zero
      lk = 1'b0;
      rc(8'h42, 8'h00);
      rc(8'h45, 8'h00);
      // Second reset in mid-run must restore the writable registers
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      rc(8'h3E, 8'h00);
      rc(8'h3F, 8'h06);
      report_and_stop;
   end
endmodule

// file: shared/dgcs_pkg.sv
// Constants for the gain, calibration and status register bank
package dgcs_pkg;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] DGCS_ADDR_BOOST    = 8'h3E;
   localparam logic [7:0] DGCS_ADDR_CALIB    = 8'h3F;
   localparam logic [7:0] DGCS_ADDR_STATUS   = 8'h40;
   localparam logic [7:0] DGCS_ADDR_PIN      = 8'h41;
   localparam logic [7:0] DGCS_ADDR_RATIO_B0 = 8'h42;
   localparam logic [7:0] DGCS_ADDR_RATIO_B1 = 8'h43;
   localparam logic [7:0] DGCS_ADDR_RATIO_B2 = 8'h44;
   localparam logic [7:0] DGCS_ADDR_RATIO_B3 = 8'h45;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0]  DGCS_RST_BOOST = 8'h00;
   localparam logic [7:0]  DGCS_RST_CALIB = 8'h06;
   localparam logic [31:0] DGCS_RST_RATIO = 32'h0000_0000;
   localparam logic [7:0]  DGCS_RST_RDATA = 8'h00;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int DGCS_CAL_EN_BIT    = 7;
   localparam int DGCS_CAL_SEL_BIT   = 6;
   localparam int DGCS_CAL_LATCH_BIT = 5;
   localparam int DGCS_MOD_LSB       = 2;
   localparam int DGCS_MOD_MSB       = 3;
   localparam int DGCS_ID_LSB        = 2;
   localparam int DGCS_MUTE_BIT      = 1;
   localparam int DGCS_LOCK_BIT      = 0;
   localparam int DGCS_PIN_BIT       = 0;
   localparam int DGCS_CHANNELS      = 8;

   // Identification code: value is arbitrary
   localparam logic [5:0] DGCS_PART_ID = 6'h15;

   // Stable modulator setting expected from the host
   localparam logic [1:0] DGCS_MOD_STABLE = 2'h2;
endpackage

// file: src/dgcs_ratio_snapshot.sv
// Snapshot store for the 32-bit rate-ratio number
`timescale 1ns/1ps
module dgcs_ratio_snapshot (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_capture,
   input  wire logic [31:0] i_value,
   output logic      [31:0] o_value
);
   logic [31:0] value_reg;
   logic [31:0] value_next;

   always_comb begin
      value_next = value_reg;
      if (i_capture) begin
         value_next = i_value;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         value_reg <= dgcs_pkg::DGCS_RST_RATIO;
      end else begin
         value_reg <= value_next;
      end
   end

   assign o_value = value_reg;
endmodule

// file: src/dgcs_regs.sv
// Gain, calibration and status register bank of the converter
`timescale 1ns/1ps
module dgcs_regs (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   // Byte register port from the serial control interface
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic        i_reg_wr,
   input  wire logic [7:0]  i_reg_wdata,
   input  wire logic        i_reg_rd,
   output logic      [7:0]  o_reg_rdata,
   output logic             o_reg_rvalid,
   // Datapath status, same clock
   input  wire logic        i_pcm_mode,
   input  wire logic        i_automute_active,
   input  wire logic        i_loop_locked,
   input  wire logic        i_timing_master,
   input  wire logic        i_fixed_oversample_clock_mode,
   input  wire logic [31:0] i_rate_ratio,
   input  wire logic [31:0] i_nco_ratio,
   // Asynchronous pin
   input  wire logic        i_general_pin_one,
   // Controls to the datapath
   output logic      [7:0]  o_channel_boost_active,
   output logic             o_calib_enable,
   output logic             o_calib_use_second_analog_input,
   output logic             o_calib_continuous,
   output logic      [1:0]  o_modulator_shaping,
   output logic             o_nco_enable
);
   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   function automatic logic addr_is(input logic [7:0] a,
                                    input logic [7:0] target);
      addr_is = (a == target);
   endfunction

   // ---------------------------------------------------------------
   // Pin synchroniser
   // ---------------------------------------------------------------
   logic pin_meta_reg;
   logic pin_sync_reg;
   logic pin_meta_next;
   logic pin_sync_next;

   always_comb begin
      pin_meta_next = i_general_pin_one;
      pin_sync_next = pin_meta_reg;
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
      end else begin
         pin_meta_reg <= pin_meta_next;
         pin_sync_reg <= pin_sync_next;
      end
   end

   // ---------------------------------------------------------------
   // Writable registers
   // ---------------------------------------------------------------
   logic [7:0] channel_boost_enables_reg;
   logic [7:0] channel_boost_enables_next;
   logic [7:0] calibration_modulator_config_reg;
   logic [7:0] calibration_modulator_config_next;

   always_comb begin
      channel_boost_enables_next        = channel_boost_enables_reg;
      calibration_modulator_config_next = calibration_modulator_config_reg;
      if (i_reg_wr && addr_is(i_reg_addr, dgcs_pkg::DGCS_ADDR_BOOST)) begin
         channel_boost_enables_next = i_reg_wdata;
      end
      if (i_reg_wr && addr_is(i_reg_addr, dgcs_pkg::DGCS_ADDR_CALIB)) begin
         // Stored as written; a wrong modulator code only hurts noise
         calibration_modulator_config_next = i_reg_wdata;
      end
      // Other offsets have no write path at all
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         channel_boost_enables_reg        <= dgcs_pkg::DGCS_RST_BOOST;
         calibration_modulator_config_reg <= dgcs_pkg::DGCS_RST_CALIB;
      end else begin
         channel_boost_enables_reg        <= channel_boost_enables_next;
         calibration_modulator_config_reg <= calibration_modulator_config_next;
      end
   end

   // ---------------------------------------------------------------
   // Controls to the datapath
   // ---------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < dgcs_pkg::DGCS_CHANNELS; ch++) begin : g_boost
         // Gain stage sits before channel mapping, so index is pre-map
         assign o_channel_boost_active[ch] =
            channel_boost_enables_reg[ch] & i_pcm_mode;
      end
   endgenerate

   logic cal_en;
   logic cal_sel;
   assign cal_en  =
      calibration_modulator_config_reg[dgcs_pkg::DGCS_CAL_EN_BIT];
   assign cal_sel =
      calibration_modulator_config_reg[dgcs_pkg::DGCS_CAL_SEL_BIT];

   // Cleared select is reserved, so calibration waits for it
   assign o_calib_enable = cal_en & cal_sel;
   assign o_calib_use_second_analog_input = cal_sel;
   assign o_calib_continuous = o_calib_enable &
      calibration_modulator_config_reg[dgcs_pkg::DGCS_CAL_LATCH_BIT];
   assign o_modulator_shaping = calibration_modulator_config_reg
      [dgcs_pkg::DGCS_MOD_MSB:dgcs_pkg::DGCS_MOD_LSB];
   assign o_nco_enable = (i_nco_ratio != 32'h0000_0000);

   // ---------------------------------------------------------------
   // Status composition
   // ---------------------------------------------------------------
   logic       lock_flag;
   logic [7:0] status_byte;
   logic [7:0] pin_byte;

   assign lock_flag = (i_loop_locked & ~i_timing_master) | i_timing_master
                    | i_fixed_oversample_clock_mode | o_nco_enable;

   always_comb begin
      status_byte = 8'h00;
      status_byte[7:dgcs_pkg::DGCS_ID_LSB] = dgcs_pkg::DGCS_PART_ID;
      status_byte[dgcs_pkg::DGCS_MUTE_BIT] = i_automute_active;
      status_byte[dgcs_pkg::DGCS_LOCK_BIT] = lock_flag;
      pin_byte = 8'h00;
      pin_byte[dgcs_pkg::DGCS_PIN_BIT] = pin_sync_reg;
   end

   // ---------------------------------------------------------------
   // Ratio snapshot
   // ---------------------------------------------------------------
   logic        ratio_capture;
   logic [31:0] ratio_live;
   logic [31:0] ratio_held;

   // Unlocked loop offers no meaningful ratio, so zero is captured
   assign ratio_live = i_loop_locked ? i_rate_ratio
                                     : dgcs_pkg::DGCS_RST_RATIO;
   assign ratio_capture = i_reg_rd &&
      addr_is(i_reg_addr, dgcs_pkg::DGCS_ADDR_RATIO_B0);

   dgcs_ratio_snapshot u_snapshot (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_capture (ratio_capture),
      .i_value   (ratio_live),
      .o_value   (ratio_held)
   );

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic       rvalid_reg;
   logic       rvalid_next;

   always_comb begin
      rdata_next  = rdata_reg;
      rvalid_next = i_reg_rd;
      if (i_reg_rd) begin
         case (i_reg_addr)
            dgcs_pkg::DGCS_ADDR_BOOST: begin
               rdata_next = channel_boost_enables_reg;
            end
            dgcs_pkg::DGCS_ADDR_CALIB: begin
               rdata_next = calibration_modulator_config_reg;
            end
            dgcs_pkg::DGCS_ADDR_STATUS: begin
               rdata_next = status_byte;
            end
            dgcs_pkg::DGCS_ADDR_PIN: begin
               rdata_next = pin_byte;
            end
            dgcs_pkg::DGCS_ADDR_RATIO_B0: begin
               // Same value that the snapshot takes this edge
               rdata_next = ratio_live[7:0];
            end
            dgcs_pkg::DGCS_ADDR_RATIO_B1: begin
               rdata_next = ratio_held[15:8];
            end
            dgcs_pkg::DGCS_ADDR_RATIO_B2: begin
               rdata_next = ratio_held[23:16];
            end
            dgcs_pkg::DGCS_ADDR_RATIO_B3: begin
               rdata_next = ratio_held[31:24];
            end
            default: begin
               rdata_next = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         rdata_reg  <= dgcs_pkg::DGCS_RST_RDATA;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign o_reg_rdata  = rdata_reg;
   assign o_reg_rvalid = rvalid_reg;
endmodule
